// File: hw/icma_regs.svh
// Register offsets, field positions, keys and timing counts of the config memory access block
// Assumes inclusion by bare name from the design file and the testbench
`ifndef ICMA_REGS_SVH
`define ICMA_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ICMA_OFF_SLVADDR   8'h0a
`define ICMA_OFF_PROGCNT   8'h88
`define ICMA_OFF_CTRL      8'h89
`define ICMA_OFF_ADDRHI    8'h8b
`define ICMA_OFF_ADDRLO    8'h8c
`define ICMA_OFF_NVDATA    8'h8d
`define ICMA_OFF_SHDATA    8'h8e
`define ICMA_OFF_ROMDATA   8'h8f
`define ICMA_OFF_UNLOCK    8'h90
`define ICMA_OFF_PAGESEL   8'h91

// ----------------------------------------
// Control and status bits
// ----------------------------------------
`define ICMA_BIT_COMMIT    6
`define ICMA_BIT_FAIL      5
`define ICMA_BIT_BUSY      2
`define ICMA_BIT_PROG      0

// ----------------------------------------
// Values
// ----------------------------------------
`define ICMA_UNLOCK_KEY    8'hea
`define ICMA_HARD_ADDR     7'h50
`define ICMA_SOFT_UPPER    5'h14
`define ICMA_NV_SLVADDR    9'h00b
`define ICMA_NV_USERID     9'h00c
`define ICMA_STRAP_LO_BITS 2'h0
`define ICMA_STRAP_MI_BITS 2'h1
`define ICMA_STRAP_HI_BITS 2'h3
`define ICMA_BASE_BYTES    9'h080
`define ICMA_PAGE_LAST     9'h03f
`define ICMA_MEM_LAST      9'h1ff
`define ICMA_NUM_PAGES     4'h6
`define ICMA_LAST_PAGE     3'h5
`define ICMA_FIFO_DEPTH    16

// ----------------------------------------
// Timing
// ----------------------------------------
`define ICMA_CLK_PERIOD_NS 4
`define ICMA_GLITCH_NS     50
`define ICMA_GLITCH_CYC    ((`ICMA_GLITCH_NS + `ICMA_CLK_PERIOD_NS - 1) / `ICMA_CLK_PERIOD_NS)

`endif

// File: hw/icma_pkg.sv
// Types shared by the config memory access block
// Assumes the register header sits beside it
`default_nettype none
package icma_pkg;

  typedef enum logic [1:0] {
    ICMA_LVL_LOW  = 2'h0,
    ICMA_LVL_MID  = 2'h1,
    ICMA_LVL_HIGH = 2'h2
  } icma_level_type;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } icma_wr_type;

  typedef enum logic [4:0] {
    ICMA_ST_IDLE = 5'h01,
    ICMA_ST_RX   = 5'h02,
    ICMA_ST_ACK  = 5'h04,
    ICMA_ST_TX   = 5'h08,
    ICMA_ST_TACK = 5'h10
  } icma_bus_st_type;

  typedef enum logic [3:0] {
    ICMA_E_IDLE   = 4'h1,
    ICMA_E_LOAD   = 4'h2,
    ICMA_E_COMMIT = 4'h4,
    ICMA_E_PROG   = 4'h8
  } icma_eng_st_type;

endpackage
`default_nettype wire

// File: hw/icma_top.sv
// I2C slave register port with shadow, nonvolatile and ROM access engines
// Assumes SCL and SDA arrive asynchronously; SDA is open drain, resolved outside
// How it works
// - Start/stop seen as SDA edge, SCL high
// - Pins ignore pulses shorter than 50 ns
// - Receiver pulls SDA low on ninth clock
// - Ack address byte only on own address
// - Write ends in stop; read ends on nack
// - Address hard 1010000 or nv byte plus strap
// - Read: pointer write, repeated start, read
// - Pointer increments per data byte, byte registers
// - Commit bit copies registers into shadow page
// - Shadow writes at pointer, then pointer increments
// - Port reads advance pointer; access ends at stop
// - Byte 12 user identifier via shadow path
// - Six nv pages, strap picked, loaded from nv into registers at reset
// - Busy reads 1, nv reads blocked while programming
// - Programming needs unlock key 0xEA written first
// - Program copies shadow to nv, counter increments only if no fault seen
// - Failure bit set, held until the next successful program
// - Nv data reads at low 9 pointer bits, then advance 12-bit pointer
// - ROM reads 12-bit pointer, then advance
`timescale 1ns/1ps
`default_nettype none
`include "icma_regs.svh"

// ----------------------------------------
// Pin filter
// ----------------------------------------
module icma_glitch_filter #(
  parameter int unsigned CYC = `ICMA_GLITCH_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_raw,
  output logic      o_level
);
  logic       s1_r, s2_r, s3_r;
  logic [4:0] cnt_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= i_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_r   <= 5'h00;
      o_level <= 1'b1;
    end else if (s2_r != s3_r || s3_r == o_level) begin
      cnt_r <= 5'h00;
    end else if (cnt_r == 5'(CYC - 1)) begin
      cnt_r   <= 5'h00;
      o_level <= s3_r;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_glitch_reject;
    (o_level != $past(o_level)) |-> ($past(cnt_r) == 5'(CYC - 1));
  endproperty
  a_glitch_reject: assert property (p_glitch_reject) else $error("filter output moved early");
endmodule

// ----------------------------------------
// Write FIFO
// ----------------------------------------
module icma_fifo #(
  parameter int unsigned W     = 16,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_r, rd_r;

  assign o_valid = (wr_r != rd_r);
  assign o_ready = (wr_r != {~rd_r[AW], rd_r[AW-1:0]});
  assign o_data  = mem[rd_r[AW-1:0]];

  always_ff @(posedge i_clk_sys) begin
    if (i_valid && o_ready) begin
      mem[wr_r[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (i_valid && o_ready) begin
        wr_r <= wr_r + (AW+1)'(1);
      end
      if (o_valid && i_ready) begin
        rd_r <= rd_r + (AW+1)'(1);
      end
    end
  end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module icma_top (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic                    i_scl,
  input  wire logic                    i_sda,
  output logic                         o_sda_out,
  output logic                         o_sda_oe,
  input  wire logic                    i_hard_pin_mode,
  input  wire icma_pkg::icma_level_type i_address_strap_pin,
  input  wire icma_pkg::icma_level_type i_page_strap_a,
  input  wire icma_pkg::icma_level_type i_page_strap_b,
  input  wire logic                    i_nv_fault,
  output logic                         o_nv_busy,
  output logic                         o_nv_fail
);
  import icma_pkg::*;

  logic [7:0]  regs   [256];
  logic [7:0]  shadow [512];
  logic [7:0]  nv     [512];
  logic        scl_f, sda_f, scl_d_r, sda_d_r;
  logic        scl_rise, scl_fall, start_ev, stop_ev;
  icma_bus_st_type st_r;
  icma_eng_st_type eng_r;
  logic [2:0]  bit_cnt_r;
  logic [1:0]  byte_idx_r;
  logic [7:0]  shreg_r, tx_r, reg_ptr_r, rd_byte, rx_byte;
  logic        rw_r, ack_r, byte_done_r, tx_load, port_rd_inc;
  logic [6:0]  slv_addr;
  logic [4:0]  soft_upper_r;
  logic [1:0]  strap_bits_r;
  logic        hard_r, cap_pend_r;
  logic [2:0]  page_strap_r, commit_page_r;
  logic [8:0]  e_cnt_r, page_base;
  logic [11:0] mem_addr_r;
  logic        armed_r, busy_r, fail_r, fault_seen_r;
  logic [7:0]  prog_cnt_r, addr_hi_r, addr_lo_r, unlock_r, pagesel_r;
  icma_wr_type push_w, pop_w;
  logic        push_v, push_rdy, pop_v, pop_rdy, drain;
  logic        req_commit, req_prog;

  // ----------------------------------------
  // Pin filters and bus conditions
  // ----------------------------------------
  icma_glitch_filter #(.CYC(`ICMA_GLITCH_CYC)) u_scl_flt (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_raw     (i_scl),
    .o_level   (scl_f)
  );
  icma_glitch_filter #(.CYC(`ICMA_GLITCH_CYC)) u_sda_flt (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_raw     (i_sda),
    .o_level   (sda_f)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_f;
      sda_d_r <= sda_f;
    end
  end

  assign scl_rise = scl_f && !scl_d_r;
  assign scl_fall = !scl_f && scl_d_r;
  assign start_ev = scl_f && scl_d_r && !sda_f && sda_d_r;
  assign stop_ev  = scl_f && scl_d_r && sda_f && !sda_d_r;
  assign rx_byte  = {shreg_r[6:0], sda_f};

  // ----------------------------------------
  // Slave address and straps
  // ----------------------------------------
  assign slv_addr = hard_r ? `ICMA_HARD_ADDR : {soft_upper_r, strap_bits_r};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      cap_pend_r   <= 1'b1;
      hard_r       <= 1'b1;
      strap_bits_r <= `ICMA_STRAP_LO_BITS;
      page_strap_r <= 3'h0;
    end else if (cap_pend_r) begin
      cap_pend_r <= 1'b0;
      hard_r     <= i_hard_pin_mode;
      unique case (i_address_strap_pin)
        ICMA_LVL_LOW:  strap_bits_r <= `ICMA_STRAP_LO_BITS;
        ICMA_LVL_MID:  strap_bits_r <= `ICMA_STRAP_MI_BITS;
        ICMA_LVL_HIGH: strap_bits_r <= `ICMA_STRAP_HI_BITS;
        default:       strap_bits_r <= `ICMA_STRAP_LO_BITS;
      endcase
      if ({1'b0, i_page_strap_a, 1'b0} + {2'b00, i_page_strap_a} + {2'b00, i_page_strap_b} > {1'b0, `ICMA_LAST_PAGE})
        page_strap_r <= `ICMA_LAST_PAGE;
      else
        page_strap_r <= 3'({1'b0, i_page_strap_a, 1'b0} + {2'b00, i_page_strap_a} + {2'b00, i_page_strap_b});
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    unique case (reg_ptr_r)
      `ICMA_OFF_SLVADDR: rd_byte = {slv_addr, 1'b0};
      `ICMA_OFF_PROGCNT: rd_byte = prog_cnt_r;
      `ICMA_OFF_CTRL: begin
        rd_byte = 8'h00;
        rd_byte[`ICMA_BIT_COMMIT] = (eng_r == ICMA_E_COMMIT);
        rd_byte[`ICMA_BIT_FAIL]   = fail_r;
        rd_byte[`ICMA_BIT_BUSY]   = busy_r;
      end
      `ICMA_OFF_ADDRHI:  rd_byte = addr_hi_r;
      `ICMA_OFF_ADDRLO:  rd_byte = addr_lo_r;
      `ICMA_OFF_NVDATA:  rd_byte = (armed_r && !busy_r) ? nv[mem_addr_r[8:0]] : 8'h00;
      `ICMA_OFF_SHDATA:  rd_byte = armed_r ? shadow[mem_addr_r[8:0]] : 8'h00;
      `ICMA_OFF_ROMDATA: rd_byte = armed_r ? (mem_addr_r[7:0] ^ {mem_addr_r[11:8], mem_addr_r[11:8]}) : 8'h00;
      `ICMA_OFF_UNLOCK:  rd_byte = unlock_r;
      `ICMA_OFF_PAGESEL: rd_byte = pagesel_r;
      default:           rd_byte = regs[reg_ptr_r];
    endcase
  end

  // ----------------------------------------
  // Serial state machine
  // ----------------------------------------
  assign tx_load = scl_fall && ((st_r == ICMA_ST_ACK && rw_r) || (st_r == ICMA_ST_TACK && ack_r));
  assign port_rd_inc = tx_load && armed_r && (reg_ptr_r == `ICMA_OFF_NVDATA ||
                       reg_ptr_r == `ICMA_OFF_SHDATA || reg_ptr_r == `ICMA_OFF_ROMDATA);
  assign push_v = scl_rise && st_r == ICMA_ST_RX && bit_cnt_r == 3'h7 && byte_idx_r == 2'h2;
  assign push_w = '{ptr: reg_ptr_r, data: rx_byte};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_r        <= ICMA_ST_IDLE;
      bit_cnt_r   <= 3'h0;
      byte_idx_r  <= 2'h0;
      shreg_r     <= 8'h00;
      tx_r        <= 8'h00;
      reg_ptr_r   <= 8'h00;
      rw_r        <= 1'b0;
      ack_r       <= 1'b0;
      byte_done_r <= 1'b0;
      o_sda_oe    <= 1'b0;
    end else if (start_ev) begin
      st_r        <= ICMA_ST_RX;
      bit_cnt_r   <= 3'h0;
      byte_idx_r  <= 2'h0;
      byte_done_r <= 1'b0;
      rw_r        <= 1'b0;
      o_sda_oe    <= 1'b0;
    end else if (stop_ev) begin
      st_r     <= ICMA_ST_IDLE;
      o_sda_oe <= 1'b0;
    end else if (tx_load) begin
      st_r      <= ICMA_ST_TX;
      tx_r      <= rd_byte;
      o_sda_oe  <= ~rd_byte[7];
      bit_cnt_r <= 3'h0;
      reg_ptr_r <= reg_ptr_r + 8'h01;
    end else begin
      unique case (st_r)
        ICMA_ST_IDLE: o_sda_oe <= 1'b0;
        ICMA_ST_RX: begin
          if (scl_rise) begin
            shreg_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              byte_done_r <= 1'b1;
              byte_idx_r  <= (byte_idx_r == 2'h2) ? 2'h2 : byte_idx_r + 2'h1;
              unique case (byte_idx_r)
                2'h0: begin
                  ack_r <= (rx_byte[7:1] == slv_addr);
                  rw_r  <= rx_byte[0];
                  if (rx_byte[7:1] != slv_addr) st_r <= ICMA_ST_IDLE;
                end
                2'h1: begin
                  ack_r     <= 1'b1;
                  reg_ptr_r <= rx_byte;
                end
                default: begin
                  ack_r <= push_rdy;
                  if (push_rdy) reg_ptr_r <= reg_ptr_r + 8'h01;
                end
              endcase
            end
          end else if (scl_fall && byte_done_r) begin
            byte_done_r <= 1'b0;
            st_r        <= ICMA_ST_ACK;
            o_sda_oe    <= ack_r;
          end
        end
        ICMA_ST_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            st_r     <= ICMA_ST_RX;
          end
        end
        ICMA_ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_r == 3'h7) begin
              st_r     <= ICMA_ST_TACK;
              o_sda_oe <= 1'b0;
            end else begin
              tx_r      <= {tx_r[6:0], 1'b0};
              o_sda_oe  <= ~tx_r[6];
              bit_cnt_r <= bit_cnt_r + 3'h1;
            end
          end
        end
        ICMA_ST_TACK: begin
          if (scl_rise) ack_r <= ~sda_f;
          else if (scl_fall) st_r <= ICMA_ST_IDLE;
        end
      endcase
    end
  end
  assign o_sda_out = 1'b0;

  // ----------------------------------------
  // Write FIFO and drain
  // ----------------------------------------
  icma_fifo #(.W($bits(icma_wr_type)), .DEPTH(`ICMA_FIFO_DEPTH)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_valid   (push_v),
    .o_ready   (push_rdy),
    .i_data    (push_w),
    .o_valid   (pop_v),
    .i_ready   (pop_rdy),
    .o_data    (pop_w)
  );
  assign pop_rdy    = (eng_r == ICMA_E_IDLE) && !cap_pend_r;
  assign drain      = pop_v && pop_rdy;
  assign req_commit = drain && pop_w.ptr == `ICMA_OFF_CTRL && pop_w.data[`ICMA_BIT_COMMIT] &&
                      {1'b0, pagesel_r[2:0]} < `ICMA_NUM_PAGES && pagesel_r[7:3] == 5'h00;
  assign req_prog   = drain && pop_w.ptr == `ICMA_OFF_CTRL && pop_w.data[`ICMA_BIT_PROG] &&
                      unlock_r == `ICMA_UNLOCK_KEY;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      addr_hi_r <= 8'h00;
      addr_lo_r <= 8'h00;
      unlock_r  <= 8'h00;
      pagesel_r <= 8'h00;
    end else if (drain) begin
      unique case (pop_w.ptr)
        `ICMA_OFF_ADDRHI:  addr_hi_r <= pop_w.data;
        `ICMA_OFF_ADDRLO:  addr_lo_r <= pop_w.data;
        `ICMA_OFF_UNLOCK:  unlock_r  <= pop_w.data;
        `ICMA_OFF_PAGESEL: pagesel_r <= pop_w.data;
        default: ;
      endcase
    end
  end

  // Memory pointer
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mem_addr_r <= 12'h000;
    end else if (drain && pop_w.ptr == `ICMA_OFF_ADDRHI) begin
      mem_addr_r[11:8] <= pop_w.data[3:0];
    end else if (drain && pop_w.ptr == `ICMA_OFF_ADDRLO) begin
      mem_addr_r[7:0] <= pop_w.data;
    end else if (port_rd_inc || (drain && pop_w.ptr == `ICMA_OFF_SHDATA && armed_r)) begin
      mem_addr_r <= mem_addr_r + 12'h001;
    end
  end

  // Port access lives only inside one transaction
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      armed_r <= 1'b0;
    end else if (drain && (pop_w.ptr == `ICMA_OFF_ADDRHI || pop_w.ptr == `ICMA_OFF_ADDRLO)) begin
      armed_r <= 1'b1;
    end else if (stop_ev) begin
      armed_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Copy engine
  // ----------------------------------------
  assign page_base = `ICMA_BASE_BYTES + {(eng_r == ICMA_E_LOAD) ? page_strap_r : commit_page_r, 6'h00};

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      eng_r         <= ICMA_E_IDLE;
      e_cnt_r       <= 9'h000;
      commit_page_r <= 3'h0;
    end else if (cap_pend_r) begin
      eng_r   <= ICMA_E_LOAD;
      e_cnt_r <= 9'h000;
    end else begin
      unique case (eng_r)
        ICMA_E_IDLE: begin
          e_cnt_r <= 9'h000;
          if (req_prog) begin
            eng_r <= ICMA_E_PROG;
          end else if (req_commit) begin
            eng_r         <= ICMA_E_COMMIT;
            commit_page_r <= pagesel_r[2:0];
          end
        end
        ICMA_E_LOAD, ICMA_E_COMMIT: begin
          e_cnt_r <= e_cnt_r + 9'h001;
          if (e_cnt_r == `ICMA_PAGE_LAST) eng_r <= ICMA_E_IDLE;
        end
        ICMA_E_PROG: begin
          e_cnt_r <= e_cnt_r + 9'h001;
          if (e_cnt_r == `ICMA_MEM_LAST) eng_r <= ICMA_E_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (eng_r == ICMA_E_LOAD) begin
      regs[e_cnt_r[7:0]] <= nv[page_base + e_cnt_r];
    end else if (drain) begin
      regs[pop_w.ptr] <= pop_w.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (eng_r == ICMA_E_COMMIT) begin
      shadow[page_base + e_cnt_r] <= regs[e_cnt_r[7:0]];
    end else if (drain && pop_w.ptr == `ICMA_OFF_SHDATA && armed_r) begin
      shadow[mem_addr_r[8:0]] <= pop_w.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (eng_r == ICMA_E_PROG) begin
      nv[e_cnt_r] <= shadow[e_cnt_r];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      soft_upper_r <= `ICMA_SOFT_UPPER;
    end else if (eng_r == ICMA_E_LOAD && e_cnt_r == `ICMA_PAGE_LAST) begin
      soft_upper_r <= nv[`ICMA_NV_SLVADDR][7:3];
    end
  end

  // Programming status
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      busy_r       <= 1'b0;
      fail_r       <= 1'b0;
      fault_seen_r <= 1'b0;
      prog_cnt_r   <= 8'h00;
    end else if (eng_r == ICMA_E_IDLE && req_prog) begin
      busy_r       <= 1'b1;
      fault_seen_r <= 1'b0;
    end else if (eng_r == ICMA_E_PROG) begin
      fault_seen_r <= fault_seen_r | i_nv_fault;
      if (e_cnt_r == `ICMA_MEM_LAST) begin
        busy_r <= 1'b0;
        fail_r <= fault_seen_r | i_nv_fault;
        if (!(fault_seen_r | i_nv_fault)) prog_cnt_r <= prog_cnt_r + 8'h01;
      end
    end
  end
  assign o_nv_busy = busy_r;
  assign o_nv_fail = fail_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  property p_start_rx;
    start_ev |=> (st_r == ICMA_ST_RX) && (bit_cnt_r == 3'h0) && (byte_idx_r == 2'h0);
  endproperty
  a_start_rx: assert property (p_start_rx) else $error("start not taken");

  property p_stop_idle;
    stop_ev && !start_ev |=> (st_r == ICMA_ST_IDLE) && !o_sda_oe && (!armed_r || $past(drain));
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not end transfer");

  property p_ack_low;
    (st_r == ICMA_ST_RX) && scl_fall && byte_done_r && ack_r && !start_ev && !stop_ev |=> o_sda_oe;
  endproperty
  a_ack_low: assert property (p_ack_low) else $error("ack not driven");

  property p_addr_miss;
    (st_r == ICMA_ST_RX) && scl_rise && bit_cnt_r == 3'h7 && byte_idx_r == 2'h0 &&
      rx_byte[7:1] != slv_addr && !start_ev && !stop_ev |=> (st_r == ICMA_ST_IDLE) [*2];
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address answered");

  property p_ptr_inc;
    tx_load && !start_ev && !stop_ev |=> reg_ptr_r == $past(reg_ptr_r) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

  property p_busy;
    eng_r == ICMA_E_PROG |-> busy_r && o_nv_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy low while programming");

  property p_locked;
    drain && pop_w.ptr == `ICMA_OFF_CTRL && pop_w.data[`ICMA_BIT_PROG] && unlock_r != `ICMA_UNLOCK_KEY
      |=> eng_r != ICMA_E_PROG;
  endproperty
  a_locked: assert property (p_locked) else $error("programmed while locked");

  property p_count;
    eng_r == ICMA_E_PROG && e_cnt_r == `ICMA_MEM_LAST && !fault_seen_r && !i_nv_fault
      |=> prog_cnt_r == $past(prog_cnt_r) + 8'h01 && !fail_r && !busy_r;
  endproperty
  a_count: assert property (p_count) else $error("count or status wrong after success");

  property p_fail;
    eng_r == ICMA_E_PROG && e_cnt_r == `ICMA_MEM_LAST && i_nv_fault |=> fail_r && $stable(prog_cnt_r);
  endproperty
  a_fail: assert property (p_fail) else $error("failure not flagged");

  c_read_byte: cover property (tx_load ##[1:1000] (st_r == ICMA_ST_TACK));
  c_commit:    cover property (eng_r == ICMA_E_COMMIT ##64 eng_r == ICMA_E_IDLE);
  c_program:   cover property ($fell(busy_r) && !fail_r);
endmodule

`default_nettype wire

// File: dv/icma_master.sv
// I2C master model: drives SCL and open-drain SDA
// Assumes the bench ands SDA with the pull-up wire
`timescale 1ns/1ps
`default_nettype none
module icma_master (
  input  wire logic i_clk_sys,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (8 * n) @(posedge i_clk_sys);
  endtask
  // One bit, SDA moves while SCL low
  task automatic bitx(input logic b, output logic r);
    o_scl <= 1'b0;
    w(1);
    o_sda <= b;
    w(3);
    o_scl <= 1'b1;
    w(2);
    r = i_sda;
    w(2);
  endtask
  task automatic start;
    o_scl <= 1'b0;
    w(1);
    o_sda <= 1'b1;
    w(3);
    o_scl <= 1'b1;
    w(4);
    o_sda <= 1'b0;
    w(4);
  endtask
  task automatic stop;
    o_scl <= 1'b0;
    w(1);
    o_sda <= 1'b0;
    w(3);
    o_scl <= 1'b1;
    w(4);
    o_sda <= 1'b1;
    w(4);
  endtask
  // Byte MSB first, ninth bit a=1 releases
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
    k = ~k;
  endtask
endmodule
`default_nettype wire

// File: dv/icma_top_tb.sv
// Self-checking bench for the config memory access block
// Assumes design files and master model compile first
`timescale 1ns/1ps
`default_nettype none
`include "icma_regs.svh"
module icma_top_tb;
  import icma_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       fault = 1'b0;
  logic       scl, msda, oe, sout, busy, fail, k;
  logic [7:0] q, c0;
  logic [7:0] dev = 8'ha0;
  logic       hard = 1'b1;
  icma_level_type astr = ICMA_LVL_LOW, pstb = ICMA_LVL_LOW;
  wire        sda = msda & (oe ? sout : 1'b1);
  int         bad_count = 0;
  int         n_checks = 0;
  always #2 clk = ~clk;
  icma_master M (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl), .o_sda(msda));
  icma_top DUT (.i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sout),
    .o_sda_oe(oe), .i_hard_pin_mode(hard), .i_address_strap_pin(astr),
    .i_page_strap_a(ICMA_LVL_LOW), .i_page_strap_b(pstb), .i_nv_fault(fault),
    .o_nv_busy(busy), .o_nv_fail(fail));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] a, e);
    n_checks++;
    if (a !== e) begin
      bad_count++;
      $display("[FAIL] %0t %h %h", $time, a, e);
    end
  endtask
  task automatic put(input logic [7:0] d);
    M.xfer(d, 1'b1, q, k);
    chk(k, 1'b1);
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    M.xfer(8'hff, last, q, k);
    chk(q, e);
  endtask
  task automatic sel(input logic [7:0] p, input logic rd);
    M.start();
    put(dev);
    put(p);
    if (rd) begin
      M.start();
      put(dev | 8'h01);
    end
  endtask
  task automatic wr(input logic [7:0] p, d);
    sel(p, 1'b0);
    put(d);
    M.stop();
  endtask
  task automatic mrd(input logic [7:0] hi, lo, port, e);
    sel(`ICMA_OFF_ADDRHI, 1'b0);
    put(hi);
    put(lo);
    sel(port, 1'b1);
    get(e, 1'b1);
    M.stop();
  endtask
  task automatic wbusy;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_addr;
    M.start();
    M.xfer(8'ha2, 1'b1, q, k);
    chk(k, 1'b0);
    M.stop();
    sel(`ICMA_OFF_SLVADDR, 1'b1);
    get({`ICMA_HARD_ADDR, 1'b0}, 1'b1);
    M.stop();
  endtask
  task automatic t_reg;
    sel(8'h20, 1'b0);
    put(8'h5a);
    put(8'ha5);
    M.stop();
    sel(8'h20, 1'b1);
    get(8'h5a, 1'b0);
    get(8'ha5, 1'b1);
    M.stop();
    chk(oe, 1'b0);
  endtask
  task automatic t_mem;
    wr(`ICMA_OFF_PAGESEL, 8'h01);
    wr(`ICMA_OFF_CTRL, 8'h40);
    mrd(8'h00, 8'he0, `ICMA_OFF_SHDATA, 8'h5a);
    sel(`ICMA_OFF_ADDRHI, 1'b0);
    put(8'h01);
    put(8'h10);
    sel(`ICMA_OFF_SHDATA, 1'b0);
    put(8'h3c);
    M.stop();
    sel(`ICMA_OFF_ADDRHI, 1'b0);
    put(8'h00);
    put(8'h0b);
    sel(`ICMA_OFF_SHDATA, 1'b0);
    put(8'ha8);
    sel(`ICMA_OFF_SHDATA, 1'b0);
    put(8'h5c);
    M.stop();
    mrd(8'h01, 8'h10, `ICMA_OFF_SHDATA, 8'h3c);
    mrd(8'h03, 8'h47, `ICMA_OFF_ROMDATA, 8'h74);
    sel(`ICMA_OFF_ROMDATA, 1'b1);
    get(8'h00, 1'b1);
    M.stop();
  endtask
  task automatic t_prog;
    sel(`ICMA_OFF_PROGCNT, 1'b1);
    M.xfer(8'hff, 1'b1, c0, k);
    M.stop();
    wr(`ICMA_OFF_CTRL, 8'h01);
    chk(busy, 1'b0);
    wr(`ICMA_OFF_UNLOCK, `ICMA_UNLOCK_KEY);
    wr(`ICMA_OFF_CTRL, 8'h01);
    chk(busy, 1'b1);
    wbusy();
    chk({busy, fail}, 2'b00);
    sel(`ICMA_OFF_PROGCNT, 1'b1);
    get(c0 + 8'h01, 1'b1);
    M.stop();
    mrd(8'h01, 8'h10, `ICMA_OFF_NVDATA, 8'h3c);
    @(posedge clk);
    fault <= 1'b1;
    wr(`ICMA_OFF_CTRL, 8'h01);
    wbusy();
    chk(fail, 1'b1);
    fault <= 1'b0;
    wr(`ICMA_OFF_UNLOCK, 8'h00);
  endtask
  task automatic t_soft;
    @(posedge clk);
    rst  <= 1'b1;
    hard <= 1'b0;
    astr <= ICMA_LVL_MID;
    pstb <= ICMA_LVL_MID;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    dev = 8'haa;
    sel(`ICMA_OFF_SLVADDR, 1'b1);
    get(8'haa, 1'b1);
    M.stop();
    sel(8'h20, 1'b1);
    get(8'h5a, 1'b1);
    M.stop();
    mrd(8'h00, 8'h0c, `ICMA_OFF_NVDATA, 8'h5c);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_addr();
    t_reg();
    t_mem();
    t_prog();
    t_soft();
    finish_test();
  end
  initial begin
    #380000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
